// ---- logic/agop_pkg.sv ----
`default_nettype none
package agop_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] GAIN_OFS = 8'h00;
  localparam logic [7:0] TRIP_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  // Field positions
  localparam int GAIN_W = 5;
  localparam int TRIP_LVL_W = 7;
  localparam int CTRL_QSEL_BIT = 0;
  // Reset values
  localparam logic [4:0] GAIN_RST = 5'h04;
  localparam logic [7:0] TRIP_RST = 8'hff;
  localparam logic CTRL_QSEL_RST = 1'b0;
  // Gain codes: code 0 is -2 dB, step 0.5 dB, code 16 is +6 dB
  localparam logic [4:0] GAIN_0DB = 5'h04;
  localparam logic [4:0] GAIN_MAX = 5'h10;
  localparam int GAIN_FRAC = 12;
  localparam logic [13:0] GAIN_UNITY = 14'h1000;
  // Data widths
  localparam int RAW_W = 14;
  localparam int OUT_W = 16;
  localparam int PROD_W = 30;
  localparam int MAG_W = 18;
  localparam int CMP_W = 25;
  localparam logic [6:0] TRIP_DIV = 7'h7f;
  localparam int TRIP_SHIFT = 15;
  // Latencies in sampling clock cycles
  localparam int DATA_LAT = 23;
  localparam int FAST_LAT = 9;
  localparam int NCH = 2;
endpackage : agop_pkg
`default_nettype wire

// ---- logic/agop_top.sv ----
// Notes on behaviour
// R01: Sample leaves output 23 cycles after capture.
// R02: Gain -2 to 6 dB, half-dB steps.
// R03: Gain resets to 0 dB.
// R04: Code flag when 16-bit word overflows.
// R05: Early flag on threshold, nine cycles later.
// R06: Pins carry code flag by default.
// R07: Select bit routes early flag to pins.
// R08: At 0 dB trip fraction is field/127.
// R09: Positive gain scales trip by 10^(-g/20).
// R10: Software writes threshold top bit as zero.
// R11: Each channel's pin shows only its own.
`timescale 1ns/100ps
`default_nettype none
module agop_top
  import agop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [agop_pkg::RAW_W-1:0] raw_a,
  input wire logic [agop_pkg::RAW_W-1:0] raw_b,
  output logic [agop_pkg::OUT_W-1:0] dout_a,
  output logic [agop_pkg::OUT_W-1:0] dout_b,
  output logic chan_a_overload_pin,
  output logic chan_b_overload_pin
);
  import agop_pkg::*;

  // ---------------------------------------------------------------
  // Gain lookup, Q12 factors of 10^(g/20)
  // ---------------------------------------------------------------
  // Each factor rounded to nearest, so one rule rebuilds the table
  function automatic logic [13:0] gain_factor(input logic [4:0] code);
    case (code)
      5'h00: gain_factor = 14'd3254;
      5'h01: gain_factor = 14'd3446;
      5'h02: gain_factor = 14'd3651;
      5'h03: gain_factor = 14'd3867;
      5'h05: gain_factor = 14'd4339;
      5'h06: gain_factor = 14'd4596;
      5'h07: gain_factor = 14'd4868;
      5'h08: gain_factor = 14'd5157;
      5'h09: gain_factor = 14'd5462;
      5'h0a: gain_factor = 14'd5786;
      5'h0b: gain_factor = 14'd6129;
      5'h0c: gain_factor = 14'd6492;
      5'h0d: gain_factor = 14'd6876;
      5'h0e: gain_factor = 14'd7284;
      5'h0f: gain_factor = 14'd7715;
      5'h10: gain_factor = 14'd8173;
      default: gain_factor = GAIN_UNITY;
    endcase
  endfunction : gain_factor

  // Register address decode, shared by write enable and error answer
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == GAIN_OFS) || (a == TRIP_OFS) ||
               (a == CTRL_OFS) || (a == STAT_OFS);
  endfunction : addr_hit

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic [GAIN_W-1:0] gain_code_r;
  logic [7:0] trip_r;
  logic qsel_r;
  logic wr_en;
  logic [NCH-1:0] pin_r;
  logic [NCH-1:0] code_ovr_out;
  logic [31:0] rd_nxt;

  assign wr_en = ce && psel && penable && pready && pwrite && addr_hit(paddr);

  // Read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      GAIN_OFS: rd_nxt[GAIN_W-1:0] = gain_code_r;
      TRIP_OFS: rd_nxt[7:0] = trip_r;
      CTRL_OFS: rd_nxt[CTRL_QSEL_BIT] = qsel_r;
      STAT_OFS: rd_nxt[3:0] = {code_ovr_out, pin_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after setup, zero wait in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
      pslverr <= psel && !penable && !addr_hit(paddr);
    end
  end

  // Writable settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_code_r <= GAIN_RST; // R03
      trip_r <= TRIP_RST;
      qsel_r <= CTRL_QSEL_RST;
    end else if (wr_en) begin
      case (paddr)
        GAIN_OFS: gain_code_r <= (pwdata[GAIN_W-1:0] > GAIN_MAX) ?
                                 GAIN_MAX : pwdata[GAIN_W-1:0]; // R02
        TRIP_OFS: trip_r <= pwdata[7:0];
        CTRL_OFS: qsel_r <= pwdata[CTRL_QSEL_BIT];
        default: qsel_r <= qsel_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-channel sample path and overload detection
  // ---------------------------------------------------------------
  logic [RAW_W-1:0] raw_in [NCH];
  logic [OUT_W-1:0] dout_w [NCH];
  logic signed [OUT_W-1:0] gain_out [NCH];
  logic [NCH-1:0] code_ovr_r;
  logic [NCH-1:0] fast_r;
  logic [CMP_W-1:0] trip_cmp;
  logic gain_pos;

  assign raw_in[0] = raw_a;
  assign raw_in[1] = raw_b;
  assign gain_pos = gain_code_r > GAIN_0DB;
  // Trip level over full scale, only the seven low bits count
  assign trip_cmp = CMP_W'(trip_r[TRIP_LVL_W-1:0]) << TRIP_SHIFT; // R08

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch // R11
      logic signed [OUT_W-1:0] cap_r;
      logic signed [PROD_W-1:0] prod;
      logic signed [MAG_W-1:0] scaled;
      logic signed [MAG_W-1:0] lvl;
      logic [MAG_W-1:0] mag;
      logic [OUT_W-1:0] dl_d [DATA_LAT-1];
      logic [DATA_LAT-2:0] dl_o;
      logic [FAST_LAT-3:0] dl_f;

      assign prod = cap_r * $signed({1'b0, gain_factor(gain_code_r)});
      assign scaled = prod[GAIN_FRAC+MAG_W-1:GAIN_FRAC];
      // Level seen by the trip compare
      assign lvl = gain_pos ? scaled : MAG_W'(cap_r); // R09
      assign mag = lvl[MAG_W-1] ? MAG_W'(-lvl) : MAG_W'(lvl);

      // Capture stage, 14-bit code left aligned in 16 bits
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_r <= 16'sh0000;
        end else if (ce) begin
          cap_r <= {raw_in[c], 2'b00};
        end
      end

      // Gain, saturation and both overload compares
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gain_out[c] <= 16'sh0000;
          code_ovr_r[c] <= 1'b0;
          fast_r[c] <= 1'b0;
        end else if (ce) begin
          if (scaled > 18'sh07fff) begin
            gain_out[c] <= 16'sh7fff;
            code_ovr_r[c] <= 1'b1; // R04
          end else if (scaled < -18'sh08000) begin
            gain_out[c] <= 16'sh8000;
            code_ovr_r[c] <= 1'b1; // R04
          end else begin
            gain_out[c] <= scaled[OUT_W-1:0]; // R02
            code_ovr_r[c] <= 1'b0;
          end
          fast_r[c] <= (CMP_W'(mag) * CMP_W'(TRIP_DIV)) > trip_cmp; // R08
        end
      end

      // Delay lines to the fixed output latencies
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int i = 0; i < DATA_LAT - 1; i++) begin
            dl_d[i] <= 16'h0000;
          end
          dl_o <= '0;
          dl_f <= '0;
        end else if (ce) begin
          dl_d[0] <= gain_out[c]; // R01
          for (int i = 1; i < DATA_LAT - 1; i++) begin
            dl_d[i] <= dl_d[i-1];
          end
          dl_o <= {dl_o[DATA_LAT-3:0], code_ovr_r[c]};
          dl_f <= {dl_f[FAST_LAT-4:0], fast_r[c]}; // R05
        end
      end

      assign dout_w[c] = dl_d[DATA_LAT-2];
      assign code_ovr_out[c] = dl_o[DATA_LAT-2];

      // Pin source: code flag aligned with data, or early flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_r[c] <= 1'b0;
        end else if (ce) begin
          pin_r[c] <= qsel_r ? dl_f[FAST_LAT-3] : // R07
                               dl_o[DATA_LAT-3]; // R06
        end
      end
    end
  endgenerate

  assign dout_a = dout_w[0];
  assign dout_b = dout_w[1];
  assign chan_a_overload_pin = pin_r[0];
  assign chan_b_overload_pin = pin_r[1];

  // ---------------------------------------------------------------
  // Checks; latency and pin checks armed only after a long unbroken run of ce
  // ---------------------------------------------------------------
  logic [4:0] ce_run_r;
  logic run_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_run_r <= 5'h00;
    end else if (!ce) begin
      ce_run_r <= 5'h00;
    end else if (ce_run_r != 5'h1f) begin
      ce_run_r <= ce_run_r + 5'h01;
    end
  end
  assign run_ok = ce && (ce_run_r == 5'h1f);

  a_data_latency: assert property ( // R01
    @(posedge pclk) disable iff (!presetn)
    run_ok |-> dout_a == $past(gain_out[0], 22))
    else $error("data latency wrong");
  a_gain_reset: assert property ( // R03
    @(posedge pclk) disable iff (!presetn)
    $past(!presetn) |-> gain_code_r == GAIN_0DB)
    else $error("gain not 0 dB after reset");
  a_gain_unity: assert property ( // R02
    @(posedge pclk) disable iff (!presetn)
    (ce && $past(ce) && gain_code_r == GAIN_0DB && $stable(gain_code_r))
    |-> gain_out[1] == $past(g_ch[1].cap_r))
    else $error("0 dB gain changed sample");
  a_code_flag: assert property ( // R04
    @(posedge pclk) disable iff (!presetn)
    (ce && $past(ce)) |-> code_ovr_r[0] ==
      ($past(g_ch[0].scaled) > 18'sh07fff ||
       $past(g_ch[0].scaled) < -18'sh08000))
    else $error("code overload flag wrong");
  a_fast_pin: assert property ( // R05
    @(posedge pclk) disable iff (!presetn)
    (run_ok && $past(qsel_r))
    |-> chan_a_overload_pin == $past(fast_r[0], 8))
    else $error("early flag not nine cycles");
  a_default_pin: assert property ( // R06
    @(posedge pclk) disable iff (!presetn)
    (run_ok && !qsel_r && !$past(qsel_r))
    |-> chan_b_overload_pin == $past(code_ovr_r[1], 22))
    else $error("pin not code flag aligned to data");
  a_trip_unity: assert property ( // R08
    @(posedge pclk) disable iff (!presetn)
    (ce && $past(ce) && !$past(gain_pos)) |-> fast_r[0] ==
      ($past(CMP_W'(g_ch[0].mag)) * 127 > $past(trip_cmp)))
    else $error("trip compare wrong at 0 dB");
  a_trip_gain: assert property ( // R09
    @(posedge pclk) disable iff (!presetn)
    (ce && $past(ce) && $past(gain_pos)) |-> fast_r[1] ==
      ($past(CMP_W'(g_ch[1].scaled[MAG_W-1] ? -g_ch[1].scaled :
                    g_ch[1].scaled)) * 127 > $past(trip_cmp)))
    else $error("positive gain not applied to trip");
  // Channel B copies, each pin follows its own channel only; then gain range and ready checks
  a_code_flag_b: assert property ( // R04
    @(posedge pclk) disable iff (!presetn)
    (ce && $past(ce)) |-> code_ovr_r[1] ==
      ($past(g_ch[1].scaled) > 18'sh07fff ||
       $past(g_ch[1].scaled) < -18'sh08000))
    else $error("code overload flag wrong on b");
  a_fast_pin_b: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    (run_ok && $past(qsel_r))
    |-> chan_b_overload_pin == $past(fast_r[1], 8))
    else $error("channel b early flag wrong");
  a_gain_clamp: assert property ( // R02
    @(posedge pclk) disable iff (!presetn)
    gain_code_r <= GAIN_MAX)
    else $error("gain code above range");
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable) |=> pready)
    else $error("no answer after setup");
endmodule : agop_top
`default_nettype wire

// ---- testbench/agop_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host-side overload monitor
// ----------------------------------------
module agop_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_a,
  input wire logic pin_b,
  output logic [15:0] hits_a,
  output logic [15:0] hits_b
);
  // Count overload cycles, channels kept apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits_a <= 16'h0000;
      hits_b <= 16'h0000;
    end else begin
      hits_a <= hits_a + {15'h0000, pin_a};
      hits_b <= hits_b + {15'h0000, pin_b};
    end
  end
endmodule : agop_host
`default_nettype wire

// ---- testbench/adc_gain_overrange_path_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_gain_overrange_path_tb;
  import agop_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, x;
  logic [13:0] raw_a, raw_b;
  logic [15:0] dout_a, dout_b;
  logic pin_a, pin_b;
  logic [15:0] hits_a, hits_b;
  logic [3:0] st;
  int ca, cb;
  logic [13:0] sa [0:99];
  logic [13:0] sb [0:99];
  logic [16:0] e;
  int miscompares, n_compared, t, g, s, lag;
  int gains [4] = '{0, 4, 16, 20};
  // ----------------------------------------
  // Design, host monitor, clock
  // ----------------------------------------
  agop_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_a(raw_a),
    .raw_b(raw_b), .dout_a(dout_a), .dout_b(dout_b),
    .chan_a_overload_pin(pin_a), .chan_b_overload_pin(pin_b));
  agop_host u_host (.pclk(pclk), .presetn(presetn), .pin_a(pin_a),
    .pin_b(pin_b), .hits_a(hits_a), .hits_b(hits_b));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Own count of pin cycles, to hold the host monitor to
  always @(negedge pclk) begin
    if (presetn) begin
      ca <= ca + pin_a;
      cb <= cb + pin_b;
    end
  end
  // Xorshift source for sample values
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  // Reference: {pin, word} for one sample
  function automatic logic [16:0] mdl(logic signed [13:0] r, int gc,
                                      int tr, logic sel);
    int v, gq, p, d;
    logic cf, ef;
    if (gc > 16) gc = 16;
    v = r * 4;
    gq = int'(4096.0 * 10.0 ** ((gc - 4) / 40.0));
    p = (v * gq) >>> 12;
    d = (p > 32767) ? 32767 : ((p < -32768) ? -32768 : p);
    cf = (p > 32767) || (p < -32768);
    if (gc > 4) v = p;
    ef = ((v < 0 ? -v : v) * 127) > ((tr & 127) << 15);
    return {sel ? ef : cf, d[15:0]};
  endfunction : mdl
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One APB transfer, waits for pready
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    #300000;
    miscompares++;
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    x = 32'd80;
    {presetn, psel, penable, pwrite, raw_a, raw_b} = '0;
    {paddr, pwdata, miscompares, n_compared} = '0;
    ce = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, GAIN_OFS, 32'h0);
    chk("gain", {27'h0, GAIN_RST}, rd);
    apb(1'b0, TRIP_OFS, 32'h0);
    chk("trip", 32'h000000ff, rd);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    for (int k = 0; k < 8; k++) begin
      g = (k < 4) ? gains[k] : int'(rnd() & 32'h0000_001f);
      t = 32 + k * 8;
      s = k % 2;
      lag = s ? 10 : 24;
      apb(1'b1, GAIN_OFS, g);
      apb(1'b1, TRIP_OFS, t);
      apb(1'b1, CTRL_OFS, s);
      apb(1'b0, GAIN_OFS, 32'h0);
      chk("gain", (g > 16) ? 32'h10 : g, rd);
      for (int j = 0; j < 100; j++) begin
        @(posedge pclk);
        void'(rnd());
        sa[j] = x[13:0];
        raw_a <= x[13:0];
        void'(rnd());
        sb[j] = x[13:0];
        raw_b <= x[13:0];
        @(negedge pclk);
        if (j >= 24) begin
          e = mdl(sa[j-24], g, t, 1'b0);
          chk("dout_a", {16'h0, e[15:0]}, {16'h0, dout_a});
          e = mdl(sb[j-24], g, t, 1'b0);
          chk("dout_b", {16'h0, e[15:0]}, {16'h0, dout_b});
          e = mdl(sa[j-lag], g, t, s[0]);
          chk("pin_a", {31'h0, e[16]}, {31'h0, pin_a});
          e = mdl(sb[j-lag], g, t, s[0]);
          chk("pin_b", {31'h0, e[16]}, {31'h0, pin_b});
        end
      end
      // Held inputs settle, then the status word must match
      repeat (30) @(posedge pclk);
      apb(1'b0, STAT_OFS, 32'h0);
      e = mdl(sa[99], g, t, 1'b0);
      st[2] = e[16];
      e = mdl(sb[99], g, t, 1'b0);
      st[3] = e[16];
      e = mdl(sa[99], g, t, s[0]);
      st[0] = e[16];
      e = mdl(sb[99], g, t, s[0]);
      st[1] = e[16];
      chk("status", {28'h0, st}, rd);
    end
    @(negedge pclk);
    chk("hits_a", ca, {16'h0, hits_a});
    chk("hits_b", cb, {16'h0, hits_b});
    end_of_test();
  end
endmodule : adc_gain_overrange_path_tb
`default_nettype wire
